// >>> hdl/edge_sel_detect.v
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_defines.vh"

module edge_sel_detect (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Pin and polarity
    input wire pin_in,
    input wire falling_sel,
    // Event
    output reg edge_pulse
);

    reg sync1_r;
    reg sync2_r;
    reg prev_r;

    // ---------------------------------------------
    // Two-stage synchroniser, then edge compare
    // ---------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            edge_pulse <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            // 1 selects falling edge, 0 rising
            if (falling_sel) begin
                edge_pulse <= prev_r & ~sync2_r;
            end else begin
                edge_pulse <= ~prev_r & sync2_r;
            end
        end
    end

endmodule
`default_nettype wire

// >>> hdl/irq_ctl_defines.vh
`ifndef IRQ_CTL_DEFINES_VH
`define IRQ_CTL_DEFINES_VH

// ---------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------
`define ADDR_CTRL 12'h000
`define ADDR_TIMED_IRQ_DISABLE_ACTIVE_CMD 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_CLEAR 12'h00c
`define ADDR_ENABLE 12'h010
`define ADDR_VECTOR 12'h014

// ---------------------------------------------
// Control register fields
// ---------------------------------------------
`define BIT_ALT_VT 15
`define BIT_TIMED_IRQ_DISABLE_ACTIVE 14
`define BIT_EP2 2
`define BIT_EP1 1
`define BIT_EP0 0
`define CTRL_RESET 16'h0000
`define CTRL_WMASK 16'h8007
`define CTRL_W 16
`define ALT_VT_RESET 1'b0
`define EP_W 3
`define EP_MSB 2
`define EP_LSB 0
`define EP_RESET 3'h0
`define UNUSED_MSB 13
`define UNUSED_LSB 3
`define UNUSED_W 11

// ---------------------------------------------
// Vector table bases, status layout
// ---------------------------------------------
`define VT_STD_BASE 16'h0004
`define VT_ALT_BASE 16'h0104
`define VT_W 16
`define EV_W 4
`define EV_TIMED_IRQ_DISABLE_ACTIVE_END 3

`endif

// >>> hdl/irq_vector_edge_control.v
// Contract
// (R1) Vector fetches use the alternate table when bit 15 is 1, else the standard one.
// (R2) Bit 15 resets to 0 so the standard table is used until software sets it.
// (R3) Bit 14 reads 1 while a timed disable is running, 0 otherwise; writes do nothing.
// (R4) External input 2 triggers on falling edge when bit 2 is 1, rising when 0.
// (R5) The three polarity bits are read/write and reset to 0, giving rising edges.
// (R6) Bits 13 to 3 always read as 0 whatever is written.
// (R7) External input 0 triggers on falling edge when bit 0 is 1, rising when 0.
// (R8) External input 1 triggers on falling edge when bit 1 is 1, rising when 0.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_defines.vh"

module irq_vector_edge_control #(
    parameter TIMED_IRQ_DISABLE_ACTIVE_W = 14
) (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // External interrupt pins
    input wire ext_irq0,
    input wire ext_irq1,
    input wire ext_irq2,
    // To vector fetch and edge logic
    output reg alt_vector_table_select,
    output reg [15:0] vector_base,
    output reg timed_irq_disable_active,
    output reg [2:0] ext_irq_edge,
    // Interrupt
    output reg irq
);

    // ---------------------------------------------
    // Internal state and decode
    // ---------------------------------------------
    reg [`EP_W-1:0] edge_pol_r;
    reg [`EV_W-1:0] status_r;
    reg [`EV_W-1:0] status_nxt;
    reg [`EV_W-1:0] enable_r;
    reg [31:0] rdata_nxt;
    reg addr_ok;
    wire [`EP_W-1:0] edge_ev;
    wire [`EV_W-1:0] event_vec;
    wire timed_irq_disable_active_on;
    wire timed_irq_disable_active_done;
    wire access;
    wire wr_en;
    wire rd_en;
    wire sel_ctrl;
    wire sel_timed_irq_disable_active;
    wire sel_status;
    wire sel_clear;
    wire sel_enable;
    wire sel_vector;
    wire wr_ctrl;
    wire wr_clear;
    wire wr_enable;
    wire timed_irq_disable_active_start;
    wire [`CTRL_W-1:0] ctrl_word;
    wire [`VT_W-1:0] vector_nxt;

    // Register offset match, shared by every decode line
    function addr_hit;
        input [11:0] addr;
        input [11:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // Widen a half-word register onto the read bus
    function [31:0] widen_half;
        input [`CTRL_W-1:0] value;
        begin
            widen_half = {{(32-`CTRL_W){1'b0}}, value};
        end
    endfunction

    // Widen an event-layout register onto the read bus
    function [31:0] widen_ev;
        input [`EV_W-1:0] value;
        begin
            widen_ev = {{(32-`EV_W){1'b0}}, value};
        end
    endfunction

    // ---------------------------------------------
    // Bus phase and address decode
    // ---------------------------------------------
    // First access cycle only; pready masks the second so nothing lands twice
    assign access = psel & penable & ~pready;
    assign wr_en = access & pwrite;
    assign rd_en = access & ~pwrite;
    assign sel_ctrl = addr_hit(paddr, `ADDR_CTRL);
    assign sel_timed_irq_disable_active = addr_hit(paddr, `ADDR_TIMED_IRQ_DISABLE_ACTIVE_CMD);
    assign sel_status = addr_hit(paddr, `ADDR_STATUS);
    assign sel_clear = addr_hit(paddr, `ADDR_CLEAR);
    assign sel_enable = addr_hit(paddr, `ADDR_ENABLE);
    assign sel_vector = addr_hit(paddr, `ADDR_VECTOR);
    assign wr_ctrl = wr_en & sel_ctrl;
    assign wr_clear = wr_en & sel_clear;
    assign wr_enable = wr_en & sel_enable;
    // A zero count cancels a running disable
    assign timed_irq_disable_active_start = wr_en & sel_timed_irq_disable_active;

    // ---------------------------------------------
    // Control word as software sees it
    // ---------------------------------------------
    assign ctrl_word[`BIT_ALT_VT] = alt_vector_table_select; // R1
    assign ctrl_word[`BIT_TIMED_IRQ_DISABLE_ACTIVE] = timed_irq_disable_active_on; // R3
    assign ctrl_word[`UNUSED_MSB:`UNUSED_LSB] = {`UNUSED_W{1'b0}}; // R6
    assign ctrl_word[`EP_MSB:`EP_LSB] = edge_pol_r; // R5
    assign event_vec = {timed_irq_disable_active_done, edge_ev};
    assign vector_nxt = alt_vector_table_select ? `VT_ALT_BASE : `VT_STD_BASE; // R1

    // ---------------------------------------------
    // Edge detectors and disable timer
    // ---------------------------------------------
    edge_sel_detect u_ed0 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(ext_irq0),
        .falling_sel(edge_pol_r[`BIT_EP0]), // R7
        .edge_pulse(edge_ev[0])
    );

    edge_sel_detect u_ed1 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(ext_irq1),
        .falling_sel(edge_pol_r[`BIT_EP1]), // R8
        .edge_pulse(edge_ev[1])
    );

    edge_sel_detect u_ed2 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(ext_irq2),
        .falling_sel(edge_pol_r[`BIT_EP2]), // R4
        .edge_pulse(edge_ev[2])
    );

    timed_irq_disable_active_timer #(
        .CNT_W(TIMED_IRQ_DISABLE_ACTIVE_W)
    ) u_timed_irq_disable_active (
        .pclk(pclk),
        .presetn(presetn),
        .start(timed_irq_disable_active_start),
        .cycles(pwdata[TIMED_IRQ_DISABLE_ACTIVE_W-1:0]),
        .active(timed_irq_disable_active_on),
        .done_pulse(timed_irq_disable_active_done)
    );

    // ---------------------------------------------
    // Read mux
    // ---------------------------------------------
    always @* begin
        rdata_nxt = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr)
            `ADDR_CTRL: begin
                rdata_nxt = widen_half(ctrl_word); // R3 R6
            end
            `ADDR_TIMED_IRQ_DISABLE_ACTIVE_CMD: begin
                // Command register is write-only
                rdata_nxt = 32'h0000_0000;
            end
            `ADDR_STATUS: begin
                rdata_nxt = widen_ev(status_r);
            end
            `ADDR_CLEAR: begin
                // Clear register is write-only
                rdata_nxt = 32'h0000_0000;
            end
            `ADDR_ENABLE: begin
                rdata_nxt = widen_ev(enable_r);
            end
            `ADDR_VECTOR: begin
                rdata_nxt = widen_half(vector_base);
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------
    // Status update: set wins over a same-cycle clear
    // ---------------------------------------------
    always @* begin
        status_nxt = status_r;
        if (wr_clear) begin
            status_nxt = status_r & ~pwdata[`EV_W-1:0];
        end
        status_nxt = status_nxt | event_vec;
    end

    // ---------------------------------------------
    // Bus response
    // ---------------------------------------------
    // One wait state: answer one cycle into access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= access;
            pslverr <= access & ~addr_ok;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            // Unmapped reads return zero alongside pslverr
            if (addr_ok) begin
                prdata <= rdata_nxt;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ---------------------------------------------
    // Control register
    // ---------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_vector_table_select <= `ALT_VT_RESET; // R2
            edge_pol_r <= `EP_RESET; // R5
        end else if (wr_ctrl) begin
            // Bit 14 and bits 13..3 have no storage; writes there are dropped
            alt_vector_table_select <= pwdata[`BIT_ALT_VT]; // R1
            edge_pol_r <= pwdata[`EP_MSB:`EP_LSB]; // R4 R5 R7 R8
        end
    end

    // ---------------------------------------------
    // Interrupt enable and sticky status
    // ---------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_r <= {`EV_W{1'b0}};
        end else if (wr_enable) begin
            enable_r <= pwdata[`EV_W-1:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= {`EV_W{1'b0}};
        end else begin
            status_r <= status_nxt;
        end
    end

    // ---------------------------------------------
    // Registered outputs
    // ---------------------------------------------
    // Each port leaves a flop, so these lag their sources by one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_base <= `VT_STD_BASE; // R2
        end else begin
            vector_base <= vector_nxt; // R1
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timed_irq_disable_active <= 1'b0;
        end else begin
            timed_irq_disable_active <= timed_irq_disable_active_on; // R3
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_edge <= {`EP_W{1'b0}};
        end else begin
            ext_irq_edge <= edge_ev; // R4 R7 R8
        end
    end

    // Uses next status so irq rises in the same cycle as the status bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_nxt & enable_r);
        end
    end

endmodule
`default_nettype wire

// >>> hdl/timed_irq_disable_active_timer.v
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctl_defines.vh"

module timed_irq_disable_active_timer #(
    parameter CNT_W = 14
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Start request
    input wire start,
    input wire [CNT_W-1:0] cycles,
    // State
    output reg active,
    output reg done_pulse
);

    reg [CNT_W-1:0] cnt_r;

    // ---------------------------------------------
    // Down counter; active while nonzero
    // ---------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= {CNT_W{1'b0}};
            active <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= 1'b0;
            if (start && (cycles != {CNT_W{1'b0}})) begin
                cnt_r <= cycles;
                active <= 1'b1;
            end else if (start) begin
                // Zero count cancels a running disable
                cnt_r <= {CNT_W{1'b0}};
                done_pulse <= active;
                active <= 1'b0;
            end else if (active) begin
                cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
                if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    active <= 1'b0;
                    done_pulse <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> sim/irq_ctl_props.sv
`timescale 1ns/1ns
`default_nettype none
module irq_ctl_props (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // Pins and outputs
    input wire logic ext_irq0,
    input wire logic ext_irq1,
    input wire logic ext_irq2,
    input wire logic alt_vector_table_select,
    input wire logic timed_irq_disable_active,
    input wire logic [15:0] vector_base,
    input wire logic [2:0] ext_irq_edge
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_ctl = pready && !pwrite && paddr == 12'h000;
    wire wr_ctl = psel && penable && pwrite && paddr == 12'h000;
    property p_vt;
        vector_base == ($past(alt_vector_table_select) ? 16'h0104 : 16'h0004);
    endproperty
    a_vt: assert property (p_vt) else $error("vector base wrong");
    property p_rd_alt; rd_ctl |-> prdata[15] == alt_vector_table_select; endproperty
    a_rd_alt: assert property (p_rd_alt) else $error("table bit read wrong");
    property p_rst; $past(presetn) == 1'b0 |-> !alt_vector_table_select; endproperty
    a_rst: assert property (p_rst) else $error("table bit set after reset");
    property p_timed_irq_disable_active; wr_ctl && !timed_irq_disable_active |=> !timed_irq_disable_active; endproperty
    a_timed_irq_disable_active: assert property (p_timed_irq_disable_active) else $error("status bit written");
    property p_zero; rd_ctl |-> prdata[31:16] == 16'h0 && prdata[13:3] == 11'h0; endproperty
    a_zero: assert property (p_zero) else $error("unused bits not zero");
    property p_rd_timed_irq_disable_active; rd_ctl |-> prdata[14] == timed_irq_disable_active; endproperty
    a_rd_timed_irq_disable_active: assert property (p_rd_timed_irq_disable_active) else $error("status bit read wrong");
    // Pins are held long, so a pulse needs one change within the sync delay
    property p_e0; ext_irq_edge[0] |-> $past(ext_irq0) != $past(ext_irq0, 7); endproperty
    a_e0: assert property (p_e0) else $error("pin 0 event without edge");
    property p_e1; ext_irq_edge[1] |-> $past(ext_irq1) != $past(ext_irq1, 7); endproperty
    a_e1: assert property (p_e1) else $error("pin 1 event without edge");
    property p_e2; ext_irq_edge[2] |-> $past(ext_irq2) != $past(ext_irq2, 7); endproperty
    a_e2: assert property (p_e2) else $error("pin 2 event without edge");
endmodule
bind irq_vector_edge_control irq_ctl_props chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .pready, .paddr, .prdata, .ext_irq0, .ext_irq1, .ext_irq2, .alt_vector_table_select,
    .timed_irq_disable_active, .vector_base, .ext_irq_edge);
`default_nettype wire

// >>> sim/irq_vector_edge_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module irq_vector_edge_control_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic ext_irq0 = 1'b0, ext_irq1 = 1'b0, ext_irq2 = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, alt_vector_table_select, timed_irq_disable_active, err;
    logic [15:0] vector_base;
    logic [2:0] ext_irq_edge;
    logic [2:0] edge_seen = 3'h0;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    irq_vector_edge_control uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_irq0, .ext_irq1, .ext_irq2, .alt_vector_table_select,
        .vector_base, .timed_irq_disable_active, .ext_irq_edge, .irq);
    initial forever #5 pclk = ~pclk;
    // Far above the roughly 350 cycles the sequence needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        edge_seen <= edge_seen | ext_irq_edge;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test;
        end
    end
    // ----------------
    // Tasks
    // ----------------
    task automatic chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic pin(input int i, input logic v);
        if (i == 0) ext_irq0 <= v;
        else if (i == 1) ext_irq1 <= v;
        else ext_irq2 <= v;
        repeat (10) @(posedge pclk);
    endtask
    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------------
    // Sequence
    // ----------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(vector_base, 32'h4);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'hffffffff);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h8007);
        chk(alt_vector_table_select, 32'h1);
        chk(vector_base, 32'h104);
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, 12'h010, 32'hf);
        for (int i = 0; i < 3; i++) begin
            for (int p = 0; p < 2; p++) begin
                apb(1'b1, 12'h000, p << i);
                pin(i, 1'b1);
                apb(1'b0, 12'h008, 32'h0);
                chk(rd, p ? 0 : 1 << i);
                chk(irq, !p);
                apb(1'b1, 12'h00c, 32'hf);
                pin(i, 1'b0);
                apb(1'b0, 12'h008, 32'h0);
                chk(rd, p ? 1 << i : 0);
                apb(1'b1, 12'h00c, 32'hf);
            end
        end
        // Masked event still latches status
        apb(1'b1, 12'h010, 32'h0);
        pin(0, 1'b1);
        chk(irq, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h00c, 32'hf);
        apb(1'b1, 12'h004, 32'h28);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h4000);
        chk(timed_irq_disable_active, 32'h1);
        repeat (40) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        chk(timed_irq_disable_active, 32'h0);
        chk(vector_base, 32'h4);
        chk(edge_seen, 32'h7);
        finish_test;
    end
endmodule
`default_nettype wire
